//--- tb/rtgc_bb_model.sv
// Purpose: baseband controller model driving serial frames and the gain pins
// Assumes: serial clock low for three clocks and high for two, well above the minimum
// Notes: serial data toggles between frames so a stale bit never looks valid
`timescale 1ns/1ps
`default_nettype none
module rtgc_bb_model (
   input wire logic i_clk,                 // system clock
   input wire logic i_spi_sdo,             // serial read data
   input wire logic i_spi_sdo_oe,          // serial read data enable
   output logic o_spi_csn,                 // serial select, active low
   output logic o_spi_sclk,                // serial clock
   output logic o_spi_sdi,                 // serial write data
   output logic o_gain_strobe,             // nibble gain strobe
   output logic o_tx_nibble_phase,         // nibble phase
   output logic [5:0] o_tx_nibble,         // nibble bus
   output logic [5:0] o_direct_gain_port   // parallel gain port
);
   initial begin
      o_spi_csn = 1'b1;
      o_spi_sclk = 1'b0;
      o_spi_sdi = 1'b0;
      o_gain_strobe = 1'b0;
      o_tx_nibble_phase = 1'b1;
      o_tx_nibble = 6'h00;
      o_direct_gain_port = 6'h00;
   end

   // one 16-bit frame: r/w, address, data; read bits taken just before each rise
   task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
      logic [15:0] word;
      word = {rd, addr, wdata};
      rdata = 8'h00;
      @(posedge i_clk);
      o_spi_csn <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge i_clk);
         o_spi_sclk <= 1'b0;
         o_spi_sdi <= word[i];
         repeat (3) @(posedge i_clk);
         // an undriven line reads back inverted, so a missing enable shows up
         if (i < 8) rdata[i] = i_spi_sdo_oe ? i_spi_sdo : ~i_spi_sdo;
         o_spi_sclk <= 1'b1;
         @(posedge i_clk);
      end
      repeat (2) @(posedge i_clk);
      o_spi_sclk <= 1'b0;
      @(posedge i_clk);
      o_spi_csn <= 1'b1;
      o_spi_sdi <= ~o_spi_sdi;
   endtask

   // levels stand until the next call, so strobe, phase and data hold many cycles
   task automatic pins(input logic stb, input logic ph, input logic [5:0] nib,
                       input logic [5:0] dp);
      @(posedge i_clk);
      o_gain_strobe <= stb;
      o_tx_nibble_phase <= ph;
      o_tx_nibble <= nib;
      o_direct_gain_port <= dp;
   endtask
endmodule
`default_nettype wire

//--- tb/rtgc_gain_ctrl_tb_top.sv
// Purpose: self-checking bench for the rx/tx gain-code control block
// Assumes: nibble clock half period of one clock to keep the run short
// Notes: expected codes come from a small integer model kept in the bench
`timescale 1ns/1ps
`default_nettype none
module rtgc_gain_ctrl_tb_top;
   import rtgc_pkg::*;
   logic i_clk, i_resetn, i_full_duplex, i_config;
   logic spi_csn, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, gain_strobe, nib_phase;
   logic nib_clk, interp_valid;
   logic [5:0] tx_nibble, direct_port, interp_nibble, rx_code;
   rtgc_rx_stage_type rx_stage;
   rtgc_tx_atten_type tx_atten;
   int err_count = 0;
   int n_tests = 0;
   int exp_rx = 0;
   integer seed = 32'h6645AF17;

   rtgc_gain_ctrl #(.NIBBLE_HALF(1)) uut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_full_duplex(i_full_duplex),
      .i_config(i_config), .i_spi_csn(spi_csn), .i_spi_sclk(spi_sclk), .i_spi_sdi(spi_sdi),
      .o_spi_sdo(spi_sdo), .o_spi_sdo_oe(spi_sdo_oe), .i_gain_strobe(gain_strobe),
      .i_tx_nibble_phase(nib_phase), .i_tx_nibble(tx_nibble),
      .i_direct_gain_port(direct_port), .o_nibble_rate_clock(nib_clk),
      .o_interp_nibble(interp_nibble), .o_interp_valid(interp_valid),
      .o_rx_gain_code(rx_code), .o_rx_stage(rx_stage), .o_tx_atten(tx_atten));

   rtgc_bb_model bb (
      .i_spi_sdo_oe(spi_sdo_oe),
      .i_clk(i_clk), .i_spi_sdo(spi_sdo), .o_spi_csn(spi_csn), .o_spi_sclk(spi_sclk),
      .o_spi_sdi(spi_sdi), .o_gain_strobe(gain_strobe), .o_tx_nibble_phase(nib_phase),
      .o_tx_nibble(tx_nibble), .o_direct_gain_port(direct_port));

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   function automatic int rnd(input int span);
      return $unsigned($random(seed)) % span;
   endfunction
   function automatic logic [10:0] stage_of(input int c);
      return {3'h0, 2'(c / 24), 2'((c % 24) / 12), 4'(c % 12)};
   endfunction
   function automatic logic [10:0] tx_of(input int k);
      return {4'((k > 15) ? 15 : k), 6'((k > 54) ? 39 : ((k > 15) ? k - 15 : 0)), 1'b1};
   endfunction

   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic check_rx();
      settle(4);
      check({5'h00, rx_code}, 11'(exp_rx));
      check({3'h0, rx_stage}, stage_of(exp_rx));
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] unused;
      bb.frame(1'b0, a, d, unused);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      bb.frame(1'b1, a, 8'h00, d);
   endtask
   task automatic restart(input logic fd, input logic cfg);
      @(posedge i_clk);
      i_resetn <= 1'b0;
      i_full_duplex <= fd;
      i_config <= cfg;
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'b1;
      settle(2);
      exp_rx = 0;
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge i_clk);
      err_count++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end

   initial begin
      logic [7:0] d;
      int k;
      int v;
      i_resetn = 1'b0;
      i_full_duplex = 1'b1;
      i_config = 1'b0;
      restart(1'b1, 1'b0);
      bb.pins(1'b0, 1'b1, 6'h00, 6'(rnd(64)));
      settle(4);
      check({5'h00, rx_code}, 11'h000);
      check({1'b0, tx_atten.conv, tx_atten.amp}, 11'h000);
      rd(RTGC_ADDR_SRC_SEL, d);
      check({3'h0, d}, 11'h004);
      for (int i = 0; i < 4; i++) begin
         k = (i == 0) ? 60 : rnd(61);
         wr(RTGC_ADDR_RX_GAIN, 8'h40 | 8'(k));
         exp_rx = k;
         check_rx();
         rd(RTGC_ADDR_RX_GAIN, d);
         check({5'h00, d[5:0]}, 11'(k));
      end
      wr(RTGC_ADDR_RX_GAIN, 8'h15);
      check_rx();
      rd(RTGC_ADDR_RX_GAIN, d);
      check({3'h0, d}, 11'h000);
      rd(7'h33, d);
      check({3'h0, d}, 11'h000);
      settle(1);
      check({10'h000, spi_sdo_oe}, 11'h000);
      for (int i = 0; i < 5; i++) begin
         k = (i == 0) ? 63 : (i == 1) ? 15 : (i == 2) ? 16 : rnd(64);
         wr(RTGC_ADDR_TX_ATTEN, 8'h40 | 8'(k));
         settle(4);
         check(tx_atten, tx_of(k));
         rd(RTGC_ADDR_TX_ATTEN, d);
         check({5'h00, d[5:0]}, 11'(k));
      end
      wr(RTGC_ADDR_TX_PATH, 8'h01);
      settle(4);
      check({1'b0, tx_atten.conv, tx_atten.amp}, {1'b0, 4'(k % 16), 6'h00});
      wr(RTGC_ADDR_TX_PATH, 8'h00);
      // nibble-bus gain in full duplex, strobe pin
      v = rnd(61);
      bb.pins(1'b1, 1'b0, 6'(v), 6'(rnd(64)));
      exp_rx = v;
      check_rx();
      v = rnd(61);
      bb.pins(1'b0, 1'b0, 6'(v), 6'(rnd(64)));
      k = 0;
      repeat (8) begin
         settle(1);
         if (interp_valid === 1'b1 && k == 0) begin
            check({5'h00, interp_nibble}, 11'(v));
            k = 1;
         end
      end
      check(11'(k), 11'h001);
      check_rx();
      wr(RTGC_ADDR_SRC_SEL, 8'h0C);
      v = rnd(61);
      bb.pins(1'b0, 1'b0, 6'(v), 6'h00);
      exp_rx = v;
      check_rx();
      bb.pins(1'b0, 1'b1, 6'(rnd(61)), 6'h00);
      check_rx();
      wr(RTGC_ADDR_SRC_SEL, 8'h08);
      bb.pins(1'b1, 1'b0, 6'(rnd(61)), 6'h00);
      check_rx();
      bb.pins(1'b0, 1'b0, 6'h00, 6'h00);
      wr(RTGC_ADDR_CLK_CFG, 8'h01);
      repeat (4) begin
         settle(1);
         check({10'h000, nib_clk}, 11'h000);
      end
      wr(RTGC_ADDR_CLK_CFG, 8'h02);
      settle(1);
      k = int'(nib_clk);
      settle(1);
      check({10'h000, nib_clk}, 11'(k ^ 1));
      wr(RTGC_ADDR_SRC_SEL, 8'h04);
      v = rnd(61);
      bb.pins(1'b1, 1'b0, 6'(v), 6'h00);
      exp_rx = v;
      check_rx();
      // direct port, rx then tx in the safe order
      v = rnd(61);
      bb.pins(1'b0, 1'b1, 6'h3F, 6'(v));
      wr(RTGC_ADDR_SRC_SEL, 8'h20);
      exp_rx = v;
      check_rx();
      wr(RTGC_ADDR_SRC_SEL, 8'h00);
      k = rnd(64);
      bb.pins(1'b0, 1'b1, 6'h3F, 6'(k));
      wr(RTGC_ADDR_SRC_SEL, 8'h40);
      settle(4);
      check(tx_atten, tx_of(k));
      check_rx();
      // half duplex with the 3-bit map
      restart(1'b0, 1'b1);
      rd(RTGC_ADDR_SRC_SEL, d);
      check({3'h0, d}, 11'h022);
      for (int m = 0; m < 8; m++) begin
         bb.pins(1'b0, 1'b0, 6'(rnd(64)), {3'(m), 3'(rnd(8))});
         exp_rx = (m < 2) ? 0 : 8 * (m - 1);
         check_rx();
      end
      bb.pins(1'b1, 1'b0, 6'h05, 6'h10);
      exp_rx = 8;
      check_rx();
      restart(1'b0, 1'b0);
      v = rnd(61);
      bb.pins(1'b0, 1'b0, 6'h00, 6'(v));
      exp_rx = v;
      check_rx();
      // nibble loading enabled by register but refused in half duplex
      wr(RTGC_ADDR_SRC_SEL, 8'h0C);
      bb.pins(1'b1, 1'b0, 6'(rnd(61)), 6'(rnd(64)));
      check_rx();
      wrap_up();
   end
endmodule
`default_nettype wire

//--- verilog/rtgc_gain_ctrl.sv
// Purpose: rx amplifier gain and tx attenuator code registers with all load paths
// Assumes: all pins except the async i_resetn synchronous to i_clk; nibble clock made by an internal divider
// Notes: serial port frames are 16 bits; read data shifts out after the address
`timescale 1ns/1ps
`default_nettype none

module rtgc_gain_ctrl
   import rtgc_pkg::*;
#(
   parameter int NIBBLE_HALF = 2   // clocks per half period of the nibble clock
) (
   input wire logic i_clk,                          // 200 MHz clock
   input wire logic i_resetn,                       // async reset, active low
   input wire logic i_full_duplex,                  // interface select, high = full duplex
   input wire logic i_config,                       // config strap
   input wire logic i_spi_csn,                      // serial chip select, active low
   input wire logic i_spi_sclk,                     // serial clock, sampled
   input wire logic i_spi_sdi,                      // serial data in
   output logic o_spi_sdo,                          // serial data out
   output logic o_spi_sdo_oe,                       // serial data out enable
   input wire logic i_gain_strobe,                  // nibble gain strobe pin
   input wire logic i_tx_nibble_phase,              // tx nibble phase pin
   input wire logic [5:0] i_tx_nibble,              // tx nibble bus
   input wire logic [5:0] i_direct_gain_port,       // parallel gain port
   output logic o_nibble_rate_clock,                // nibble-rate clock out
   output logic [5:0] o_interp_nibble,              // nibble to interpolation filter
   output logic o_interp_valid,                     // nibble valid pulse
   output logic [5:0] o_rx_gain_code,               // current rx gain code
   output rtgc_rx_stage_type o_rx_stage,            // rx stage distribution
   output rtgc_tx_atten_type o_tx_atten             // tx attenuator controls
);
   initial begin
      if (NIBBLE_HALF < 1 || NIBBLE_HALF > 255) begin
         $error("NIBBLE_HALF out of range");
      end
   end

   logic [5:0] rx_code;
   logic rx_spi_en;
   logic [5:0] tx_code;
   logic tx_spi_en;
   logic [7:0] src_sel;
   logic [7:0] tx_path;
   logic [7:0] clk_cfg;
   logic strap_done;

   // serial port
   logic sclk_q;
   logic [4:0] bit_cnt;
   logic [15:0] shift_in;
   logic [7:0] sdo_shift;
   logic rd_phase;
   logic sclk_rise;
   logic sclk_fall;
   logic spi_wr;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic [6:0] rd_addr;

   assign sclk_rise = i_spi_sclk & ~sclk_q & ~i_spi_csn;
   assign sclk_fall = ~i_spi_sclk & sclk_q & ~i_spi_csn;
   assign spi_wr = sclk_rise && bit_cnt == RTGC_FRAME_LAST_BIT && !shift_in[14];
   assign wr_addr = shift_in[13:7];
   assign wr_data = {shift_in[6:0], i_spi_sdi};
   assign rd_addr = {shift_in[5:0], i_spi_sdi};

   function automatic logic [7:0] read_mux(input logic [6:0] a);
      logic [7:0] d;
      d = RTGC_REG_RESET;
      unique case (a)
         RTGC_ADDR_RX_GAIN: d = rx_spi_en ? {1'b0, rx_spi_en, rx_code} : 8'h00;
         RTGC_ADDR_TX_ATTEN: d = tx_spi_en ? {1'b0, tx_spi_en, tx_code} : 8'h00;
         RTGC_ADDR_SRC_SEL: d = src_sel;
         RTGC_ADDR_TX_PATH: d = tx_path;
         RTGC_ADDR_CLK_CFG: d = clk_cfg;
         default: d = RTGC_REG_RESET;
      endcase
      return d;
   endfunction

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= i_spi_sclk;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bit_cnt <= 5'h00;
         shift_in <= 16'h0000;
      end else if (i_spi_csn) begin
         bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
         shift_in <= {shift_in[14:0], i_spi_sdi};
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sdo_shift <= 8'h00;
         rd_phase <= 1'b0;
      end else if (i_spi_csn) begin
         rd_phase <= 1'b0;
      end else if (sclk_rise && bit_cnt == RTGC_ADDR_LAST_BIT && shift_in[6]) begin
         sdo_shift <= read_mux(rd_addr);
         rd_phase <= 1'b1;
      end else if (sclk_fall && rd_phase && bit_cnt > 5'h08) begin
         sdo_shift <= {sdo_shift[6:0], 1'b0};
      end
   end

   assign o_spi_sdo = sdo_shift[7];
   assign o_spi_sdo_oe = rd_phase & ~i_spi_csn;

   // control registers; mode defaults caught once after reset release
   logic [7:0] sel_default;
   always_comb begin
      sel_default = RTGC_REG_RESET;
      sel_default[RTGC_BIT_NIB_GAIN] = i_full_duplex;
      sel_default[RTGC_BIT_SEL_RX] = ~i_full_duplex;
      sel_default[RTGC_BIT_MAP3] = ~i_full_duplex & i_config;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         src_sel <= RTGC_REG_RESET;
         strap_done <= 1'b0;
      end else if (spi_wr && wr_addr == RTGC_ADDR_SRC_SEL) begin
         src_sel <= wr_data;
         strap_done <= 1'b1;
      end else if (!strap_done) begin
         src_sel <= sel_default;
         strap_done <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_path <= RTGC_REG_RESET;
         clk_cfg <= RTGC_REG_RESET;
      end else if (spi_wr && wr_addr == RTGC_ADDR_TX_PATH) begin
         tx_path <= wr_data;
      end else if (spi_wr && wr_addr == RTGC_ADDR_CLK_CFG) begin
         clk_cfg <= wr_data;
      end
   end

   // nibble-rate clock divider, edges as enables
   logic [7:0] div_cnt;
   logic nib_clk;
   logic nib_edge;
   assign nib_edge = div_cnt == 8'(NIBBLE_HALF - 1);

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div_cnt <= 8'h00;
         nib_clk <= 1'b0;
      end else if (nib_edge) begin
         div_cnt <= 8'h00;
         nib_clk <= ~nib_clk;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   logic sample_en;
   // inversion moves the sampling point to the other edge of the internal clock
   assign sample_en = nib_edge && (nib_clk == clk_cfg[RTGC_BIT_CLK_INV]);
   assign o_nibble_rate_clock = ~clk_cfg[RTGC_BIT_CLK_OFF] &
                                (nib_clk ^ clk_cfg[RTGC_BIT_CLK_INV]);

   // load sources
   logic strobe_eff;
   logic nib_load;
   logic map3;
   logic par_rx;
   logic par_tx;
   logic [5:0] par_rx_code;
   logic spi_wr_rx;
   logic spi_wr_tx;

   assign strobe_eff = i_gain_strobe | src_sel[RTGC_BIT_SW_STROBE];
   assign nib_load = sample_en && i_full_duplex && src_sel[RTGC_BIT_NIB_GAIN] &&
                     strobe_eff && !i_tx_nibble_phase;
   assign map3 = !i_full_duplex && src_sel[RTGC_BIT_MAP3];
   assign par_rx = src_sel[RTGC_BIT_SEL_RX];
   assign par_tx = src_sel[RTGC_BIT_SEL_TX];
   // 3-bit codes 0 and 1 both land on the minimum
   assign par_rx_code = !map3 ? i_direct_gain_port :
                        (i_direct_gain_port[5:4] == 2'b00) ? RTGC_RX_CODE_RESET :
                        6'(RTGC_MAP3_STEP * (i_direct_gain_port[5:3] - 3'h1));
   assign spi_wr_rx = spi_wr && wr_addr == RTGC_ADDR_RX_GAIN;
   assign spi_wr_tx = spi_wr && wr_addr == RTGC_ADDR_TX_ATTEN;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_code <= RTGC_RX_CODE_RESET;
         rx_spi_en <= 1'b0;
      end else if (spi_wr_rx) begin
         rx_spi_en <= wr_data[RTGC_BIT_SPI_EN];
         if (wr_data[RTGC_BIT_SPI_EN]) begin
            rx_code <= wr_data[5:0];
         end
      end else if (nib_load) begin
         rx_code <= i_tx_nibble;
      end else if (par_rx) begin
         rx_code <= par_rx_code;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_code <= RTGC_TX_CODE_RESET;
         tx_spi_en <= 1'b0;
      end else if (spi_wr_tx) begin
         tx_spi_en <= wr_data[RTGC_BIT_SPI_EN];
         if (wr_data[RTGC_BIT_SPI_EN]) begin
            tx_code <= wr_data[5:0];
         end
      end else if (par_tx) begin
         tx_code <= i_direct_gain_port;
      end
   end

   // nibble data to the interpolation filter while the strobe is low
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_interp_nibble <= 6'h00;
         o_interp_valid <= 1'b0;
      end else begin
         o_interp_valid <= sample_en && i_full_duplex && !strobe_eff;
         if (sample_en && i_full_duplex && !strobe_eff) begin
            o_interp_nibble <= i_tx_nibble;
         end
      end
   end

   // stage distribution table
   function automatic rtgc_rx_stage_type rx_split(input logic [5:0] code);
      rtgc_rx_stage_type s;
      logic [5:0] c;
      c = (code > RTGC_RX_CODE_MAX) ? RTGC_RX_CODE_MAX : code;
      s.stage_a = (c >= 6'(2 * RTGC_STAGE_A_STEP)) ? 2'h2 : (c >= RTGC_STAGE_A_STEP) ? 2'h1 : 2'h0;
      c = c - 6'(RTGC_STAGE_A_STEP * s.stage_a);
      s.stage_b = (c >= RTGC_STAGE_B_STEP) ? 2'h1 : 2'h0;
      c = c - 6'(RTGC_STAGE_B_STEP * s.stage_b);
      s.stage_c = c[3:0];
      return s;
   endfunction

   function automatic rtgc_tx_atten_type tx_split(input logic [5:0] code, input logic conv_only);
      rtgc_tx_atten_type t;
      logic [5:0] rest;
      t.amp_en = ~conv_only;
      if (conv_only) begin
         t.conv = code[3:0];
         t.amp = 6'h00;
      end else begin
         t.conv = (code > RTGC_CONV_SPAN) ? RTGC_CONV_SPAN[3:0] : code[3:0];
         rest = (code > RTGC_CONV_SPAN) ? code - RTGC_CONV_SPAN : 6'h00;
         t.amp = (rest > RTGC_AMP_SPAN) ? RTGC_AMP_SPAN : rest;
      end
      return t;
   endfunction

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rx_stage <= '0;
         o_tx_atten <= '0;
      end else begin
         o_rx_stage <= rx_split(rx_code);
         o_tx_atten <= tx_split(tx_code, tx_path[RTGC_BIT_CONV_ONLY]);
      end
   end

   assign o_rx_gain_code = rx_code;

   // checks
   sequence s_nib_cond;
      nib_load && !spi_wr_rx;
   endsequence

   a_spi_rx_wins: assert property (@(posedge i_clk) disable iff (!i_resetn)
      spi_wr_rx && wr_data[RTGC_BIT_SPI_EN] |=> rx_code == $past(wr_data[5:0]))
      else $error("serial rx write lost");
   a_spi_rx_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
      spi_wr_rx && !wr_data[RTGC_BIT_SPI_EN] |=> rx_code == $past(rx_code))
      else $error("rx code changed without enable bit");
   a_nib_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
      s_nib_cond |=> rx_code == $past(i_tx_nibble))
      else $error("nibble gain not loaded");
   a_nib_half_dup: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !i_full_duplex && !par_rx && !spi_wr_rx |=> $stable(rx_code))
      else $error("rx code moved in half duplex");
   a_par_tx_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
      par_tx && !spi_wr_tx |=> tx_code == $past(i_direct_gain_port))
      else $error("tx direct port not loaded");
   a_map3_code: assert property (@(posedge i_clk) disable iff (!i_resetn)
      map3 && par_rx && !spi_wr_rx && i_direct_gain_port[5:3] == 3'h7 |=> rx_code == 6'h30)
      else $error("3-bit map top code wrong");
   a_interp_pass: assert property (@(posedge i_clk) disable iff (!i_resetn)
      sample_en && i_full_duplex && !strobe_eff |=> o_interp_valid ##1 !o_interp_valid)
      else $error("nibble not passed to filter");
   a_conv_only: assert property (@(posedge i_clk) disable iff (!i_resetn)
      tx_path[RTGC_BIT_CONV_ONLY] && $stable(tx_path) |=>
         o_tx_atten.conv == $past(tx_code[3:0]) && !o_tx_atten.amp_en)
      else $error("converter-only mapping wrong");
   a_stage_sum: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $past(rx_code) <= RTGC_RX_CODE_MAX |-> 6'(RTGC_STAGE_A_STEP * o_rx_stage.stage_a) +
         6'(RTGC_STAGE_B_STEP * o_rx_stage.stage_b) + 6'(o_rx_stage.stage_c) == $past(rx_code))
      else $error("stage split does not sum");
endmodule
`default_nettype wire

//--- verilog/rtgc_pkg.sv
// Purpose: shared constants and carriers for the rx/tx gain-code control block
// Assumes: 16-bit serial frames, msb first: r/w bit, 7-bit address, 8 data bits
// Notes: register offsets are the printed ones; one clock domain
package rtgc_pkg;
   localparam logic [6:0] RTGC_ADDR_CLK_CFG = 7'h05;
   localparam logic [6:0] RTGC_ADDR_RX_GAIN = 7'h09;
   localparam logic [6:0] RTGC_ADDR_TX_ATTEN = 7'h0A;
   localparam logic [6:0] RTGC_ADDR_SRC_SEL = 7'h0B;
   localparam logic [6:0] RTGC_ADDR_TX_PATH = 7'h0E;
   // field positions
   localparam int RTGC_BIT_SPI_EN = 6;
   localparam int RTGC_BIT_SEL_TX = 6;
   localparam int RTGC_BIT_SEL_RX = 5;
   localparam int RTGC_BIT_SW_STROBE = 3;
   localparam int RTGC_BIT_NIB_GAIN = 2;
   localparam int RTGC_BIT_MAP3 = 1;
   localparam int RTGC_BIT_CONV_ONLY = 0;
   localparam int RTGC_BIT_CLK_INV = 1;
   localparam int RTGC_BIT_CLK_OFF = 0;
   // reset values
   localparam logic [5:0] RTGC_RX_CODE_RESET = 6'h00;
   localparam logic [5:0] RTGC_TX_CODE_RESET = 6'h00;
   localparam logic [7:0] RTGC_REG_RESET = 8'h00;
   // gain arithmetic, in code steps
   localparam logic [5:0] RTGC_RX_CODE_MAX = 6'h3C;
   localparam logic [5:0] RTGC_STAGE_A_STEP = 6'h18;
   localparam logic [5:0] RTGC_STAGE_B_STEP = 6'h0C;
   localparam logic [5:0] RTGC_MAP3_STEP = 6'h08;
   localparam logic [5:0] RTGC_CONV_SPAN = 6'h0F;
   localparam logic [5:0] RTGC_AMP_SPAN = 6'h27;
   // serial frame
   localparam logic [4:0] RTGC_ADDR_LAST_BIT = 5'h07;
   localparam logic [4:0] RTGC_FRAME_LAST_BIT = 5'h0F;

   typedef struct packed {
      logic [1:0] stage_a;   // 24-step coarse stage
      logic [1:0] stage_b;   // 12-step mid stage
      logic [3:0] stage_c;   // 1-step fine stage
   } rtgc_rx_stage_type;

   typedef struct packed {
      logic [3:0] conv;      // converter current attenuation, 0.5 dB steps
      logic [5:0] amp;       // line current amp attenuation, 0.5 dB steps
      logic amp_en;          // line current amp in the path
   } rtgc_tx_atten_type;
endpackage
